// ### cpsm_pkg.sv
/*
 Package for the configuration port status monitor: status byte layout,
 reset values, register map of the Avalon-MM slave, event bit positions.
 Assumes nothing of its surroundings.
*/
package cpsm_pkg;
    localparam int STAT_W = 32;
    // Status byte bit positions
    localparam int B_ERR_N = 7;
    localparam int B_SYNC = 6;
    localparam int B_RDBK = 5;
    localparam int B_ABORT_N = 4;
    // Reserved nibble, family dependent
    localparam logic [3:0] RSVD_FAM_A = 4'h_F;
    localparam logic [3:0] RSVD_FAM_B = 4'h_B;
    // Register byte addresses
    localparam logic [3:0] A_STATUS = 4'h_0;
    localparam logic [3:0] A_CTRL = 4'h_4;
    localparam logic [3:0] A_EVENT = 4'h_8;
    localparam logic [3:0] A_MASK = 4'h_C;
    // Control register bits
    localparam int C_FRAME_CRC = 0;
    localparam int C_PORT_ACTIVE = 1;
    localparam int C_FAMILY_B = 2;
    localparam logic [2:0] CTRL_RST = 3'h_2;
    // Event bits
    localparam int EV_W = 4;
    localparam int E_SYNC = 0;
    localparam int E_CRC = 1;
    localparam int E_DONE = 2;
    localparam int E_PDONE = 3;
    localparam logic [31:0] UNMAPPED = 32'h_0000_0000;

    typedef struct packed {
        logic sync_word;
        logic crc_err;
        logic crc_reset_command;
        logic command_a;
        logic frame_end;
        logic full_done;
        logic readback;
        logic abort;
    } cpsm_evt_t;

    typedef enum logic [1:0] {
        CPSM_IDLE = 2'b00,
        CPSM_SYNC = 2'b01,
        CPSM_ERRP = 2'b10,
        CPSM_ERR = 2'b11
    } cpsm_st_t;
endpackage : cpsm_pkg

// ### cpsm_top.sv
/*
 Status monitor of the internal configuration port: status byte, done and
 error outputs, frame write refusal, Avalon-MM status/control registers.
 The error sequencer keeps the byte, the init drive and the error echo in
 step; the register slave offers event flags with a mask and an interrupt.
 Assumes event inputs come from logic on clk, one-cycle pulses or levels,
 and a bus master that holds each request until waitrequest is low.
 Only one request is in flight; the answer always costs one wait cycle.
*/
// How it works
// - Status bus 32 bits, only low byte used
// - Bit 7 low after a configuration error
// - Bit 6 high once sync word received
// - Bit 5 high during readback
// - Bit 4 low during abort
// - Low nibble fixed, F or B by family
// - 0x9F before sync, 0xDF after sync
// - CRC error: 0x5F one cycle, then 0x1F
// - CRC error drives init low; reset clears
// - Retry: sync gives 0x5F, reset gives 0xDF
// - command_a without error returns to 0x9F
// - Done pin rises after full configuration
// - partial_done_out mirrors the done pin, dipping one cycle per frame end
// - partial_error_out mirrors init pin
// - Status valid only while port delivers
// - Failed frame check blocks the frame write
`timescale 1ns/100ps
module cpsm_top
    import cpsm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire cpsm_evt_t evt,
    output logic [STAT_W-1:0] status_out,
    output logic done_pin,
    output logic init_status_pin_n,
    output logic partial_done_out,
    output logic partial_error_out,
    output logic frame_write_en,
    output logic irq,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    cpsm_st_t st_r, st_nxt;
    logic [7:0] stat_r, stat_nxt;
    logic done_r, done_nxt;
    logic init_n_r, init_n_nxt;
    logic pdone_r, pdone_nxt;
    logic perr_r, perr_nxt;
    logic fwe_r, fwe_nxt;
    logic rdbk_nxt;
    logic abort_nxt;
    logic [2:0] ctrl_r, ctrl_nxt;
    logic [EV_W-1:0] ev_r, ev_nxt;
    logic [EV_W-1:0] mask_r, mask_nxt;
    logic irq_r, irq_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic ack_r, ack_nxt;
    logic [EV_W-1:0] ev_set;
    logic act;
    logic errp_first_r, errp_first_nxt;
    logic wait_r, wait_nxt;
    logic take_rd, take_wr, commit;
    logic [EV_W-1:0] ev_clr;

    function automatic logic [7:0] pack_stat(input cpsm_st_t s,
            input logic rb, input logic ab, input logic fam_b);
        logic [7:0] v;
        v = 8'h_00;
        v[B_ERR_N] = (s == CPSM_IDLE) || (s == CPSM_SYNC);
        v[B_SYNC] = (s == CPSM_SYNC) || (s == CPSM_ERRP);
        v[B_RDBK] = rb;
        v[B_ABORT_N] = ~ab;
        v[3:0] = fam_b ? RSVD_FAM_B : RSVD_FAM_A;
        return v;
    endfunction : pack_stat

    // Events other than full_done only count while this port is the bitstream path
    assign act = ctrl_r[C_PORT_ACTIVE];

    // Read word by byte address
    function automatic logic [31:0] rd_word(input logic [3:0] a,
            input logic [7:0] s, input logic [2:0] c,
            input logic [EV_W-1:0] e, input logic [EV_W-1:0] m);
        logic [31:0] w;
        w = UNMAPPED;
        case (a)
            A_STATUS: begin
                w = {24'h_00_0000, s};
            end

            A_CTRL: begin
                w = {29'h_0000_0000, c};
            end

            A_EVENT: begin
                w = {28'h_000_0000, e};
            end

            A_MASK: begin
                w = {28'h_000_0000, m};
            end

            default: begin
                // Unmapped reads return a fixed word, never stale data
                w = UNMAPPED;
            end
        endcase
        return w;
    endfunction : rd_word

    // Error sequencer: state, init pin drive, first pulse cycle
    always_comb begin
        st_nxt = st_r;
        init_n_nxt = init_n_r;
        errp_first_nxt = 1'b0;

        if (act) begin
            case (st_r)
                CPSM_IDLE: begin
                    if (evt.sync_word) begin
                        st_nxt = CPSM_SYNC;
                    end
                end

                CPSM_SYNC: begin
                    if (evt.crc_err) begin
                        st_nxt = CPSM_ERRP;
                        init_n_nxt = 1'b0;
                        errp_first_nxt = 1'b1;
                    end else if (evt.command_a) begin
                        st_nxt = CPSM_IDLE;
                    end
                end

                CPSM_ERRP: begin
                    // 0x5F both as error pulse and as retry sync
                    if (evt.crc_reset_command) begin
                        st_nxt = CPSM_SYNC;
                        init_n_nxt = 1'b1;
                    end else if (errp_first_r) begin
                        // Only the pulse decays; a retry waits for reset
                        st_nxt = CPSM_ERR;
                    end
                end

                CPSM_ERR: begin
                    // Reset alone drops the init drive, byte stays
                    if (evt.crc_reset_command) begin
                        init_n_nxt = 1'b1;
                    end
                    if (evt.sync_word) begin
                        st_nxt = CPSM_ERRP;
                    end
                end

                default: begin
                    st_nxt = CPSM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_r <= CPSM_IDLE;
            init_n_r <= 1'b1;
            errp_first_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            init_n_r <= init_n_nxt;
            errp_first_r <= errp_first_nxt;
        end
    end

    // Byte built from the next state: one edge after the event
    always_comb begin
        rdbk_nxt = act & evt.readback;
        abort_nxt = act & evt.abort;
        // Reserved nibble chosen by the family bit
        stat_nxt = pack_stat(st_nxt, rdbk_nxt, abort_nxt,
                             ctrl_r[C_FAMILY_B]);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stat_r <= {1'b1, 1'b0, 1'b0, 1'b1, RSVD_FAM_A};
        end else begin
            stat_r <= stat_nxt;
        end
    end

    // Done pin is sticky once full configuration ends
    always_comb begin
        done_nxt = done_r | evt.full_done;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
        end
    end

    // Done echo dips for one cycle per frame, as on split dies
    always_comb begin
        // Echo pins track the same next values, no extra lag
        pdone_nxt = done_nxt & ~(act & evt.frame_end);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pdone_r <= 1'b0;
        end else begin
            pdone_r <= pdone_nxt;
        end
    end

    // Error echo follows the init drive in the same cycle
    always_comb begin
        perr_nxt = init_n_nxt;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            perr_r <= 1'b1;
        end else begin
            perr_r <= perr_nxt;
        end
    end

    // Refuse a frame whose check fails
    always_comb begin
        // Pulse lasts one cycle; a failed frame gets none
        fwe_nxt = act & evt.frame_end & ~evt.crc_err
                  & ctrl_r[C_FRAME_CRC];
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fwe_r <= 1'b0;
        end else begin
            fwe_r <= fwe_nxt;
        end
    end

    // Register slave: decode a read at the first edge of a request, a write
    // and the answer at the second, so a write lands exactly where the master
    // sees waitrequest low
    always_comb begin
        // Read and write never come together
        take_rd = avs_read && !avs_write && !ack_r;
        commit = (avs_read || avs_write) && ack_r;
        take_wr = avs_write && commit;
        ack_nxt = (avs_read || avs_write) && !ack_r;
        wait_nxt = ~ack_nxt;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ack_r <= 1'b0;
            wait_r <= 1'b1;
        end else begin
            ack_r <= ack_nxt;
            wait_r <= wait_nxt;
        end
    end

    // Read word latched early, held until the next read
    always_comb begin
        rd_nxt = rd_r;
        if (take_rd) begin
            rd_nxt = rd_word(avs_address, stat_r, ctrl_r, ev_r, mask_r);
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_r <= '0;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    // Control and mask writes
    always_comb begin
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;

        if (take_wr) begin
            case (avs_address)
                A_CTRL: begin
                    ctrl_nxt = avs_writedata[2:0];
                end

                A_MASK: begin
                    mask_nxt = avs_writedata[EV_W-1:0];
                end

                default: begin
                    // Status, event and unmapped words are read only
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_r <= CTRL_RST;
            mask_r <= '0;
        end else begin
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
        end
    end

    // Event flags: set wins over the read clear
    always_comb begin
        ev_set = '0;
        ev_set[E_SYNC] = act & evt.sync_word;
        ev_set[E_CRC] = act & evt.crc_err;
        ev_set[E_DONE] = evt.full_done & ~done_r;
        ev_set[E_PDONE] = act & evt.command_a & ~evt.crc_err
                          & (st_r == CPSM_SYNC);

        // Only the bits handed to the master are cleared, so an event
        // that lands between latch and answer is kept
        ev_clr = '0;
        if (commit && avs_read && (avs_address == A_EVENT)) begin
            ev_clr = rd_r[EV_W-1:0];
        end
        ev_nxt = (ev_r & ~ev_clr) | ev_set;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ev_r <= '0;
        end else begin
            ev_r <= ev_nxt;
        end
    end

    // Interrupt taken from the next flags, so it adds no lag
    always_comb begin
        irq_nxt = |(ev_nxt & mask_nxt);
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    // Every output comes from a register
    assign status_out = {24'h_00_0000, stat_r};
    assign done_pin = done_r;
    assign init_status_pin_n = init_n_r;
    assign partial_done_out = pdone_r;
    assign partial_error_out = perr_r;
    assign frame_write_en = fwe_r;
    assign irq = irq_r;
    assign avs_readdata = rd_r;
    assign avs_waitrequest = wait_r;
endmodule : cpsm_top

// ### cpsm_chk_props.sv
/* Checker of the status monitor ports.
 Assumes it is bound into cpsm_top and the port stays active. */
`timescale 1ns/100ps
module cpsm_chk
    import cpsm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire cpsm_evt_t evt,
    input wire logic [STAT_W-1:0] status_out,
    input wire logic done_pin,
    input wire logic init_status_pin_n,
    input wire logic partial_done_out,
    input wire logic partial_error_out
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic [1:0] st = status_out[7:6];
    property p_upper; status_out[31:8] == 24'h00_0000; endproperty
    a_upper: assert property (p_upper) else $error("upper bits");
    property p_sync; evt.sync_word && st == 2'b10 |=> st == 2'b11; endproperty
    a_sync: assert property (p_sync) else $error("sync");
    property p_crc; evt.crc_err && st == 2'b11 |=> st == 2'b01 ##1
        (st == 2'b00 || $past(evt.crc_reset_command)); endproperty
    a_crc: assert property (p_crc) else $error("crc pulse");
    property p_pins; init_status_pin_n == status_out[7] &&
        partial_error_out == init_status_pin_n; endproperty
    a_pins: assert property (p_pins) else $error("error pins");
    property p_crc_reset_command; evt.crc_reset_command && st == 2'b01 |=>
        st == 2'b11 && init_status_pin_n; endproperty
    a_crc_reset_command: assert property (p_crc_reset_command) else $error("crc reset");
    property p_command_a; evt.command_a && !evt.crc_err && st == 2'b11 |=>
        st == 2'b10; endproperty
    a_command_a: assert property (p_command_a) else $error("command_a");
    property p_done; $rose(done_pin) |-> $past(evt.full_done); endproperty
    a_done: assert property (p_done) else $error("done rise");
    property p_pdone; partial_done_out |-> done_pin; endproperty
    a_pdone: assert property (p_pdone) else $error("pdone");
    c_err: cover property (status_out[7:0] == 8'h1F);
    c_pdone: cover property ($fell(partial_done_out));
    c_done: cover property ($rose(done_pin));
endmodule : cpsm_chk
bind cpsm_top cpsm_chk u_chk(.clk, .rstn, .evt, .status_out, .done_pin,
    .init_status_pin_n, .partial_done_out, .partial_error_out);

// ### cpsm_ctl_model.sv
/* Reconfiguration controller model watching the status byte.
 Assumes it samples on the port clock with no synchroniser. */
`timescale 1ns/100ps
module cpsm_ctl_model
    import cpsm_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [STAT_W-1:0] status_out,
    input wire logic partial_error_out,
    output logic retry_r
);
    logic retry_nxt;
    always_comb begin
        // Byte alone is ambiguous, so confirm with the pin
        retry_nxt = status_out[7:6] == 2'b00 && !partial_error_out;
    end
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) retry_r <= 1'b0;
        else retry_r <= retry_nxt;
    end
endmodule : cpsm_ctl_model

// ### cpsm_top_tb.sv
/* Bench of cpsm_top: event table, then register accesses.
 Assumes the checker is bound and the controller model sits beside. */
`timescale 1ns/100ps
module cpsm_top_tb
    import cpsm_pkg::*;
;
    logic clk = 0, rstn = 0, avs_read = 0, avs_write = 0;
    cpsm_evt_t evt = '0;
    logic [3:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, status_out, rd, wr, rnd;
    logic done_pin, init_status_pin_n, partial_done_out, partial_error_out;
    logic irq, retry, avs_waitrequest, fwe;
    logic [7:0] last = 8'h9F;
    logic [7:0] exp_q[$];
    logic [23:0] tbl[9] = '{24'h80_DF00, 24'h40_5F1F, 24'h80_5F00,
        24'h20_DF00, 24'h10_9F00, 24'h04_0000, 24'h08_0000, 24'h02_BF9F,
        24'h01_8F9F};
    int error_cnt = 0, cmp_count = 0;
    cpsm_top dut(.clk, .rstn, .evt, .status_out, .done_pin,
        .init_status_pin_n, .partial_done_out, .partial_error_out,
        .frame_write_en(fwe), .irq, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest);
    cpsm_ctl_model ctl(.clk, .rstn, .status_out, .partial_error_out,
        .retry_r(retry));
    initial begin
        forever #12.5 clk = ~clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [3:0] a,
            input logic [31:0] d, output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic test_done();
        if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done
    // Every change of the byte must match the oldest expectation
    always @(posedge clk) begin
        if (rstn && status_out[7:0] !== last)
            chk("status", status_out, {24'h00_0000, exp_q.pop_front()});
        last = status_out[7:0];
    end
    initial begin
        #20000;
        error_cnt++;
        test_done();
    end
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        foreach (tbl[i]) begin
            if (tbl[i][15:8] != 8'h00) exp_q.push_back(tbl[i][15:8]);
            if (tbl[i][7:0] != 8'h00) exp_q.push_back(tbl[i][7:0]);
            evt <= cpsm_evt_t'(tbl[i][23:16]);
            @(posedge clk);
            evt <= '0;
            repeat (3) @(posedge clk);
            if (i == 1) begin
                chk("init", 32'(init_status_pin_n), 32'h0000_0000);
                chk("perr", 32'(partial_error_out), 32'h0000_0000);
                chk("retry", 32'(retry), 32'h0000_0001);
            end
        end
        chk("done", 32'(done_pin), 32'h0000_0001);
        chk("pdone", 32'(partial_done_out), 32'h0000_0001);
        rnd = 32'h0000_630B;
        repeat (2) begin
            rnd = lfsr(rnd);
            wr = {28'h000_0000, rnd[3:1], 1'b1};
            bus(1'b1, A_MASK, wr, rd);
            bus(1'b0, A_MASK, wr, rd);
            chk("mask", rd, wr);
        end
        chk("irq", 32'(irq), 32'h0000_0001);
        bus(1'b0, A_EVENT, wr, rd);
        chk("event", rd, 32'h0000_000F);
        repeat (2) @(posedge clk);
        chk("irq", 32'(irq), 32'h0000_0000);
        bus(1'b1, A_CTRL, 32'h0000_0003, rd);
        evt <= cpsm_evt_t'(8'h08);
        @(posedge clk);
        evt <= cpsm_evt_t'(8'h48);
        @(posedge clk);
        chk("fwe", 32'(fwe), 32'h0000_0001);
        evt <= '0;
        @(posedge clk);
        chk("fwe", 32'(fwe), 32'h0000_0000);
        bus(1'b0, 4'h1, wr, rd);
        chk("unmapped", rd, 32'h0000_0000);
        bus(1'b0, A_STATUS, wr, rd);
        chk("stat reg", rd, 32'h0000_009F);
        chk("queue", 32'(exp_q.size()), 32'h0000_0000);
        test_done();
    end
endmodule : cpsm_top_tb
